// >>> logic/ccfg_regs.svh
`ifndef CCFG_REGS_SVH
`define CCFG_REGS_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define CCFG_IDX_CHIP_CFG 8'h08
`define CCFG_IDX_ADDR_LOW 8'h10
`define CCFG_IDX_ADDR_MID 8'h12
`define CCFG_IDX_ADDR_HIGH 8'h14
`define CCFG_IDX_BUS_CTRL 8'h20
`define CCFG_IDX_PROM_CTRL 8'h22
`define CCFG_ADDR_CHIP_CFG 8'h20
`define CCFG_ADDR_ADDR_LOW 8'h40
`define CCFG_ADDR_ADDR_MID 8'h48
`define CCFG_ADDR_ADDR_HIGH 8'h50
`define CCFG_ADDR_BUS_CTRL 8'h80
`define CCFG_ADDR_PROM_CTRL 8'h88

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCFG_CFG_ENDIAN 10
`define CCFG_CFG_PROM 9
`define CCFG_CFG_BUS8 7
`define CCFG_CFG_BUS16 6
`define CCFG_CFG_SHARED 4
`define CCFG_CFG_PKG48 1
`define CCFG_BUS_DRIVE 6
`define CCFG_BUS_CLKSEL 2
`define CCFG_PROM_DIR 5
`define CCFG_PROM_EN 4
`define CCFG_PROM_DIN 3
`define CCFG_PROM_DOUT 2
`define CCFG_PROM_SCLK 1
`define CCFG_PROM_SEL 0

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define CCFG_RST_ADDR 16'h0000
`define CCFG_RST_BUS_CTRL 16'h0000
`define CCFG_RST_PROM_CTRL 16'h0000
`define CCFG_BUS_CTRL_MASK 16'h0047
`define CCFG_PROM_CTRL_MASK 16'h0037

// ----------------------------------------------------------------
// Serial memory loader constants
// ----------------------------------------------------------------
`define CCFG_CLK_MHZ 40
`define CCFG_PROM_HALF_NS 1000
`define CCFG_PROM_HALF_CYC ((`CCFG_PROM_HALF_NS * `CCFG_CLK_MHZ + 999) / 1000)
`define CCFG_PROM_WORD_BASE 6'h01
`define CCFG_PROM_WORDS 2'd3
`define CCFG_PROM_OP_READ 3'b110
`define CCFG_PROM_CMD_BITS 4'd9
`define CCFG_PROM_DATA_BITS 5'd17

`endif

// >>> logic/ccfg_pkg.sv
package ccfg_pkg;

  typedef enum logic [1:0] {
    CCFG_RESP_OKAY = 2'b00,
    CCFG_RESP_SLVERR = 2'b10
  } ccfg_resp_t;

  typedef enum logic [1:0] {
    CCFG_LD_IDLE = 2'b00,
    CCFG_LD_CMD = 2'b01,
    CCFG_LD_DATA = 2'b10,
    CCFG_LD_GAP = 2'b11
  } ccfg_ld_state_t;

endpackage

// >>> logic/ccfg_bus_clk_div.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccfg_regs.svh"

module ccfg_bus_clk_div
  import ccfg_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Divider control
  input wire logic [1:0] div_sel,
  // Divided rate
  output logic bus_clk_en
);

  logic [1:0] cnt_reg;
  logic [1:0] last;

  always_comb begin
    unique case (div_sel)
      2'b01: last = 2'h1;
      2'b10: last = 2'h2;
      default: last = 2'h0;
    endcase
  end

  // Counts bus clock periods of one, two or three cycles.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 2'h0;
    end else if (cnt_reg >= last) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

  assign bus_clk_en = (cnt_reg >= last);

endmodule
`default_nettype wire

// >>> logic/ccfg_prom_loader.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccfg_regs.svh"

module ccfg_prom_loader
  import ccfg_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic start,
  output logic busy,
  // Serial memory pins
  output logic sel_out,
  output logic sclk_out,
  output logic dout,
  output logic dout_oe,
  input wire logic din,
  // Loaded words
  output logic word_valid,
  output logic [1:0] word_idx,
  output logic [15:0] word_data
);

  localparam int HALF = `CCFG_PROM_HALF_CYC;

  ccfg_ld_state_t state_reg;
  logic [7:0] tick_cnt_reg;
  logic tick;
  logic sclk_reg;
  logic [8:0] cmd_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] shift_reg;
  logic [1:0] idx_reg;

  assign tick = (tick_cnt_reg == 8'(HALF - 1));

  // ----------------------------------------------------------------
  // Half-period tick
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      tick_cnt_reg <= 8'h00;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Read sequence for words one to three
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    word_valid <= 1'b0;
    if (!aresetn) begin
      state_reg <= CCFG_LD_IDLE;
      sclk_reg <= 1'b0;
      sel_out <= 1'b0;
      cmd_reg <= 9'h000;
      bit_cnt_reg <= 5'h00;
      shift_reg <= 16'h0000;
      idx_reg <= 2'h0;
      word_idx <= 2'h0;
      word_data <= 16'h0000;
    end else begin
      unique case (state_reg)
        CCFG_LD_IDLE: begin
          if (start) begin
            idx_reg <= 2'h0;
            state_reg <= CCFG_LD_GAP;
          end
        end
        CCFG_LD_CMD: begin
          if (tick) begin
            sclk_reg <= ~sclk_reg;
            if (sclk_reg) begin
              cmd_reg <= {cmd_reg[7:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg - 5'h01;
              if (bit_cnt_reg == 5'h01) begin
                bit_cnt_reg <= `CCFG_PROM_DATA_BITS;
                state_reg <= CCFG_LD_DATA;
              end
            end
          end
        end
        CCFG_LD_DATA: begin
          if (tick) begin
            sclk_reg <= ~sclk_reg;
            if (sclk_reg) begin
              shift_reg <= {shift_reg[14:0], din};
              bit_cnt_reg <= bit_cnt_reg - 5'h01;
              if (bit_cnt_reg == 5'h01) begin
                word_valid <= 1'b1;
                word_idx <= idx_reg;
                word_data <= {shift_reg[14:0], din};
                idx_reg <= idx_reg + 2'h1;
                sel_out <= 1'b0;
                state_reg <= CCFG_LD_GAP;
              end
            end
          end
        end
        CCFG_LD_GAP: begin
          if (tick) begin
            if (idx_reg == `CCFG_PROM_WORDS) begin
              state_reg <= CCFG_LD_IDLE;
            end else begin
              sel_out <= 1'b1;
              cmd_reg <= {`CCFG_PROM_OP_READ, `CCFG_PROM_WORD_BASE + {4'h0, idx_reg}};
              bit_cnt_reg <= {1'b0, `CCFG_PROM_CMD_BITS};
              state_reg <= CCFG_LD_CMD;
            end
          end
        end
      endcase
    end
  end

  assign busy = (state_reg != CCFG_LD_IDLE);
  assign sclk_out = sclk_reg;
  assign dout = cmd_reg[8];
  assign dout_oe = (state_reg == CCFG_LD_CMD);

endmodule
`default_nettype wire

// >>> logic/ccfg_top.sv
// Behaviour
// - Latch serial clock strap at reset into bit 10: 0 big, 1 little endian.
// - Latch data pin strap at reset into bit 9: 1 means memory fitted.
// - Bit 7 reads 1 when the LED strap selects an 8-bit bus.
// - Bit 6 reads 1 when the LED strap selects a 16-bit bus.
// - Bit 4 reads 1 for shared address/data bus; read-only.
// - Bit 1 reads 1 for 48-pin package; whole configuration register read-only.
// - After reset with memory fitted, load three address words from word 1.
// - Software writes to address registers never touch the serial memory.
// - Words 1, 2, 3 go to low, middle and high address registers.
// - Bus control bit 6 selects pad drive 8 mA or 16 mA; reset 0.
// - Bus control bit 2 selects bus clock source; 1 reserved; reset 0.
// - Bus control bits 1-0 divide bus clock by one, two, three.
// - Memory control bit 4 hands memory pins to software; reset 0.
// - Write-only bit 5 sets software direction: 0 read, 1 write.
// - Read-only bit 3 returns the live memory data pin level.
// - Bit 2 drives memory data output during software access.
// - Bit 1 drives the memory serial clock during software access.
// - Bit 0 drives memory chip select during software access.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ccfg_regs.svh"

module ccfg_top
  import ccfg_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // Write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // Read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Straps
  input wire logic port_led_strap_pin,
  input wire logic shared_bus_strap,
  input wire logic package_48pin_strap,
  // Serial memory pins
  output logic prom_select_pin,
  input wire logic prom_serial_clock_pin_in,
  output logic prom_serial_clock_pin_out,
  output logic prom_serial_clock_pin_oe,
  input wire logic prom_data_pin_in,
  output logic prom_data_pin_out,
  output logic prom_data_pin_oe,
  // Bus clock and pad control
  output logic bus_clk_en,
  output logic bus_clk_src_sel,
  output logic pad_drive_strong
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] chip_configuration_reg;
  logic [15:0] station_address_low_reg;
  logic [15:0] station_address_middle_reg;
  logic [15:0] station_address_high_reg;
  logic [15:0] internal_bus_control_reg;
  logic [15:0] serial_prom_control_reg;
  logic load_pending_reg;
  logic out_of_reset_reg;

  logic aw_have_reg;
  logic [7:0] aw_addr_reg;
  logic w_have_reg;
  logic [15:0] w_data_reg;
  logic [1:0] w_strb_reg;
  logic wr_fire;
  logic wr_hit;
  logic [15:0] rd_value;
  logic rd_hit;

  logic ld_start;
  logic ld_busy;
  logic ld_sel;
  logic ld_sclk;
  logic ld_dout;
  logic ld_dout_oe;
  logic ld_valid;
  logic [1:0] ld_idx;
  logic [15:0] ld_data;
  logic prom_sw_access_enable;
  logic prom_sw_direction;
  logic [2:0] prom_pin_control_bits;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] val,
                                          input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = val[7:0];
    end
    if (strb[1]) begin
      res[15:8] = val[15:8];
    end
    return res & mask;
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    return (a == `CCFG_ADDR_CHIP_CFG) || (a == `CCFG_ADDR_ADDR_LOW) ||
           (a == `CCFG_ADDR_ADDR_MID) || (a == `CCFG_ADDR_ADDR_HIGH) ||
           (a == `CCFG_ADDR_BUS_CTRL) || (a == `CCFG_ADDR_PROM_CTRL);
  endfunction

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chip_configuration_reg <= 16'h0000;
      chip_configuration_reg[`CCFG_CFG_ENDIAN] <= prom_serial_clock_pin_in;
      chip_configuration_reg[`CCFG_CFG_PROM] <= prom_data_pin_in;
      chip_configuration_reg[`CCFG_CFG_BUS8] <= ~port_led_strap_pin;
      chip_configuration_reg[`CCFG_CFG_BUS16] <= port_led_strap_pin;
      chip_configuration_reg[`CCFG_CFG_SHARED] <= shared_bus_strap;
      chip_configuration_reg[`CCFG_CFG_PKG48] <= package_48pin_strap;
    end
  end

  // ----------------------------------------------------------------
  // Loader start after reset
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_pending_reg <= 1'b1;
      out_of_reset_reg <= 1'b0;
    end else begin
      out_of_reset_reg <= 1'b1;
      if (out_of_reset_reg) begin
        load_pending_reg <= 1'b0;
      end
    end
  end

  assign ld_start = out_of_reset_reg && load_pending_reg &&
                    chip_configuration_reg[`CCFG_CFG_PROM];

  ccfg_prom_loader u_loader (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(ld_start),
    .busy(ld_busy),
    .sel_out(ld_sel),
    .sclk_out(ld_sclk),
    .dout(ld_dout),
    .dout_oe(ld_dout_oe),
    .din(prom_data_pin_in),
    .word_valid(ld_valid),
    .word_idx(ld_idx),
    .word_data(ld_data)
  );

  // ----------------------------------------------------------------
  // Write address and data capture
  // ----------------------------------------------------------------
  assign awready = !aw_have_reg && !bvalid;
  assign wready = !w_have_reg && !bvalid;
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid;
  assign wr_hit = addr_known(aw_addr_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (awvalid && awready) begin
      aw_have_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg <= 1'b0;
      w_data_reg <= 16'h0000;
      w_strb_reg <= 2'b00;
    end else if (wvalid && wready) begin
      w_have_reg <= 1'b1;
      w_data_reg <= wdata[15:0];
      w_strb_reg <= wstrb[1:0];
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= CCFG_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? CCFG_RESP_OKAY : CCFG_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Station address registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      station_address_low_reg <= `CCFG_RST_ADDR;
      station_address_middle_reg <= `CCFG_RST_ADDR;
      station_address_high_reg <= `CCFG_RST_ADDR;
    end else begin
      if (ld_valid) begin
        unique case (ld_idx)
          2'h0: station_address_low_reg <= ld_data;
          2'h1: station_address_middle_reg <= ld_data;
          2'h2: station_address_high_reg <= ld_data;
          default: ;
        endcase
      end
      // Host writes only update these copies, never the memory itself.
      if (wr_fire && aw_addr_reg == `CCFG_ADDR_ADDR_LOW) begin
        station_address_low_reg <= merge16(station_address_low_reg, w_data_reg,
                                           w_strb_reg, 16'hFFFF);
      end
      if (wr_fire && aw_addr_reg == `CCFG_ADDR_ADDR_MID) begin
        station_address_middle_reg <= merge16(station_address_middle_reg, w_data_reg,
                                              w_strb_reg, 16'hFFFF);
      end
      if (wr_fire && aw_addr_reg == `CCFG_ADDR_ADDR_HIGH) begin
        station_address_high_reg <= merge16(station_address_high_reg, w_data_reg,
                                            w_strb_reg, 16'hFFFF);
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus control register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      internal_bus_control_reg <= `CCFG_RST_BUS_CTRL;
    end else if (wr_fire && aw_addr_reg == `CCFG_ADDR_BUS_CTRL) begin
      internal_bus_control_reg <= merge16(internal_bus_control_reg, w_data_reg,
                                          w_strb_reg, `CCFG_BUS_CTRL_MASK);
    end
  end

  assign pad_drive_strong = internal_bus_control_reg[`CCFG_BUS_DRIVE];
  assign bus_clk_src_sel = internal_bus_control_reg[`CCFG_BUS_CLKSEL];

  ccfg_bus_clk_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .div_sel(internal_bus_control_reg[1:0]),
    .bus_clk_en(bus_clk_en)
  );

  // ----------------------------------------------------------------
  // Serial memory control register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_prom_control_reg <= `CCFG_RST_PROM_CTRL;
    end else if (wr_fire && aw_addr_reg == `CCFG_ADDR_PROM_CTRL) begin
      serial_prom_control_reg <= merge16(serial_prom_control_reg, w_data_reg,
                                         w_strb_reg, `CCFG_PROM_CTRL_MASK);
    end
  end

  assign prom_sw_access_enable = serial_prom_control_reg[`CCFG_PROM_EN];
  assign prom_sw_direction = serial_prom_control_reg[`CCFG_PROM_DIR];
  assign prom_pin_control_bits = serial_prom_control_reg[2:0];

  // ----------------------------------------------------------------
  // Pin ownership
  // ----------------------------------------------------------------
  always_comb begin
    if (prom_sw_access_enable) begin
      prom_select_pin = prom_pin_control_bits[`CCFG_PROM_SEL];
      prom_serial_clock_pin_out = prom_pin_control_bits[`CCFG_PROM_SCLK];
      prom_data_pin_out = prom_pin_control_bits[`CCFG_PROM_DOUT];
      prom_data_pin_oe = prom_sw_direction;
    end else begin
      prom_select_pin = ld_sel;
      prom_serial_clock_pin_out = ld_sclk;
      prom_data_pin_out = ld_dout;
      prom_data_pin_oe = ld_dout_oe && ld_busy;
    end
  end

  // The clock pin is released during reset so that its strap can be sampled.
  assign prom_serial_clock_pin_oe = out_of_reset_reg;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_value = 16'h0000;
    rd_hit = 1'b1;
    unique case (araddr)
      `CCFG_ADDR_CHIP_CFG: rd_value = chip_configuration_reg;
      `CCFG_ADDR_ADDR_LOW: rd_value = station_address_low_reg;
      `CCFG_ADDR_ADDR_MID: rd_value = station_address_middle_reg;
      `CCFG_ADDR_ADDR_HIGH: rd_value = station_address_high_reg;
      `CCFG_ADDR_BUS_CTRL: rd_value = internal_bus_control_reg;
      `CCFG_ADDR_PROM_CTRL: begin
        rd_value = {11'h000, prom_sw_access_enable, prom_data_pin_in,
                    prom_pin_control_bits};
      end
      default: rd_hit = 1'b0;
    endcase
  end

  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= CCFG_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {16'h0000, rd_value};
      rresp <= rd_hit ? CCFG_RESP_OKAY : CCFG_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> sim/ccfg_top_properties.sv
`timescale 1ns/10ps
`default_nettype none

module ccfg_top_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Pins
  input wire logic bus_clk_en,
  input wire logic bus_clk_src_sel,
  input wire logic pad_drive_strong,
  input wire logic prom_select_pin,
  input wire logic prom_serial_clock_pin_out,
  input wire logic prom_data_pin_out
);
  logic [7:0] ar_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // --------------------
  // Checks
  // --------------------
  // Holds the address of the read in flight.
  always_ff @(posedge aclk) begin
    if (arvalid && arready) begin
      ar_q <= araddr;
    end
  end

  a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_read_answer: assert property (arvalid && arready |-> ##[1:2] rvalid)
    else $error("no read answer");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
    else $error("no write answer");
  a_clk_en_gap: assert property (
    !bus_clk_en ##1 !bus_clk_en |=> bus_clk_en) else $error("bus clock gap too long");
  a_cfg_fields: assert property (
    rvalid && ar_q == 8'h20 |-> (rdata & 32'hFFFFF92D) == 32'h0 && rdata[7] != rdata[6])
    else $error("bad configuration read");
  a_bus_pins: assert property (
    rvalid && ar_q == 8'h80 |-> pad_drive_strong == rdata[6] && bus_clk_src_sel == rdata[2]
    && rdata[5:3] == 3'h0 && rdata[31:7] == 25'h0) else $error("bus control mismatch");
  a_sw_pins: assert property (
    rvalid && ar_q == 8'h88 && rdata[4] |-> prom_select_pin == rdata[0] && !rdata[5]
    && prom_serial_clock_pin_out == rdata[1] && prom_data_pin_out == rdata[2])
    else $error("software pins mismatch");
  a_unmapped: assert property (
    rvalid && !(ar_q inside {8'h20, 8'h40, 8'h48, 8'h50, 8'h80, 8'h88})
    |-> rresp == 2'h2 && rdata == 32'h0) else $error("unmapped read answered");
endmodule

bind ccfg_top ccfg_top_checker u_chk (.*);

`default_nettype wire

// >>> sim/ccfg_prom_model.sv
`timescale 1ns/10ps
`default_nettype none

module ccfg_prom_model (
  // Memory pins
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  // Data pin drive
  output logic d_oe,
  output logic d_o
);
  logic [15:0] mem [0:3] = '{16'h0000, 16'h89AB, 16'h4567, 16'h0123};
  logic [8:0] cmd = 9'h000;
  int n = 0;
  int frames = 0;

  // Counts how often the chip select is raised.
  always @(posedge cs) frames++;

  initial begin
    d_oe = 1'b0;
    d_o = 1'b0;
  end

  // Takes the read command, then returns a dummy bit and the word MSB first.
  always @(posedge sk or negedge cs) begin
    if (!cs) begin
      n = 0;
      d_oe = 1'b0;
    end else begin
      n = n + 1;
      if (n <= 9) begin
        cmd = {cmd[7:0], di};
      end else begin
        d_oe = n <= 26 && cmd[8:6] == 3'b110;
        d_o = n == 10 ? ~mem[cmd[1:0]][15] : mem[cmd[1:0]][(26 - n) & 15];
      end
    end
  end
endmodule

`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  import ccfg_pkg::*;

  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic port_led_strap_pin = 1'b1, shared_bus_strap = 1'b0, package_48pin_strap = 1'b1;
  logic sk_pull = 1'b1, dat_pull = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, m_oe, m_d, bus_clk_en;
  logic prom_select_pin, prom_serial_clock_pin_out, prom_serial_clock_pin_oe;
  logic prom_data_pin_out, prom_data_pin_oe, bus_clk_src_sel, pad_drive_strong;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v;
  int mismatches = 0, num_checks = 0, i, n;
  wire logic prom_serial_clock_pin_in = prom_serial_clock_pin_oe ? prom_serial_clock_pin_out
                                                                  : sk_pull;
  wire logic prom_data_pin_in = prom_data_pin_oe ? prom_data_pin_out : (m_oe ? m_d : dat_pull);

  always #12.5 aclk = ~aclk;

  ccfg_top u_ccfg_top (.*);
  ccfg_prom_model u_ccfg_prom_model (.cs(prom_select_pin), .sk(prom_serial_clock_pin_in),
                                     .di(prom_data_pin_in), .d_oe(m_oe), .d_o(m_d));

  // --------------------
  // Bus tasks
  // --------------------
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
    if (er !== 2'bxx) chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rc(input string s, input logic [7:0] a, input logic [15:0] e,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b1;
    @(posedge aclk);
    v = rdata;
    rready <= 1'b0;
    if (s != "") begin
      chk(s, rdata, {16'h0000, e});
      chk("rresp", {30'h0, rresp}, {30'h0, er});
    end
  endtask

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // --------------------
  // Tests
  // --------------------
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    final_report;
  end

  initial begin
    do_reset;
    rc("cfg", 8'h20, 16'h0642, CCFG_RESP_OKAY);
    chk("sk_oe", {31'h0, prom_serial_clock_pin_oe}, 32'h1);
    wr(8'h20, 16'hFFFF, CCFG_RESP_OKAY);
    rc("cfg_ro", 8'h20, 16'h0642, CCFG_RESP_OKAY);
    i = 0;
    do begin
      repeat (20) @(posedge aclk);
      rc("", 8'h50, 16'h0000, CCFG_RESP_OKAY);
      i++;
    end while (v[15:0] !== 16'h0123 && i < 500);
    rc("addr_lo", 8'h40, 16'h89AB, CCFG_RESP_OKAY);
    rc("addr_mid", 8'h48, 16'h4567, CCFG_RESP_OKAY);
    rc("addr_hi", 8'h50, 16'h0123, CCFG_RESP_OKAY);
    wr(8'h40, 16'h1234, CCFG_RESP_OKAY);
    rc("addr_wr", 8'h40, 16'h1234, CCFG_RESP_OKAY);
    chk("prom_word", {16'h0000, u_ccfg_prom_model.mem[1]}, 32'h89AB);
    chk("prom_frames", u_ccfg_prom_model.frames, 32'h3);
    wstrb <= 4'h2;
    wr(8'h48, 16'hFFFF, CCFG_RESP_OKAY);
    wstrb <= 4'hF;
    rc("addr_lane", 8'h48, 16'hFF67, CCFG_RESP_OKAY);
    rc("bus_rst", 8'h80, 16'h0000, CCFG_RESP_OKAY);
    wr(8'h80, 16'hFFFF, CCFG_RESP_OKAY);
    rc("bus_ctl", 8'h80, 16'h0047, CCFG_RESP_OKAY);
    chk("pads", {30'h0, pad_drive_strong, bus_clk_src_sel}, 32'h3);
    for (i = 0; i < 3; i++) begin
      wr(8'h80, {14'h0, i[1:0]}, CCFG_RESP_OKAY);
      repeat (3) @(posedge aclk);
      n = 0;
      repeat (6) begin
        @(posedge aclk);
        n += bus_clk_en;
      end
      chk("clk_en", n, 6 / (i + 1));
    end
    rc("prom_rst", 8'h88, 16'h0008, CCFG_RESP_OKAY);
    wr(8'h88, 16'h003F, CCFG_RESP_OKAY);
    chk("sw_pins", {prom_select_pin, prom_serial_clock_pin_out, prom_data_pin_out,
                    prom_data_pin_oe}, 32'hF);
    rc("prom_ctl", 8'h88, 16'h001F, CCFG_RESP_OKAY);
    dat_pull <= 1'b0;
    wr(8'h88, 16'h0010, CCFG_RESP_OKAY);
    rc("din_lo", 8'h88, 16'h0010, CCFG_RESP_OKAY);
    chk("dat_oe", {31'h0, prom_data_pin_oe}, 32'h0);
    wr(8'h88, 16'h0007, CCFG_RESP_OKAY);
    chk("hw_pins", {prom_select_pin, prom_serial_clock_pin_out, prom_data_pin_out},
        32'h0);
    rc("unmapped", 8'h84, 16'h0000, CCFG_RESP_SLVERR);
    wr(8'h84, 16'h5555, CCFG_RESP_SLVERR);
    {sk_pull, dat_pull, port_led_strap_pin, shared_bus_strap, package_48pin_strap} <= 5'h02;
    do_reset;
    rc("cfg2", 8'h20, 16'h0090, CCFG_RESP_OKAY);
    rc("addr_rst", 8'h50, 16'h0000, CCFG_RESP_OKAY);
    for (i = 0; i < 3; i++) begin
      wr({3'h2, i[1:0], 3'h0}, {14'h2969, i[1:0]}, CCFG_RESP_OKAY);
      rc("addr_sw", {3'h2, i[1:0], 3'h0}, {14'h2969, i[1:0]}, CCFG_RESP_OKAY);
    end
    final_report;
  end
endmodule

`default_nettype wire
